//--- dmd_defs.svh
// Constants for the data-memory and special-register decode block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef DMD_DEFS_SVH
`define DMD_DEFS_SVH
`define DMD_LOW_TOP 8'h7F
`define DMD_BANK_TOP 8'h1F
`define DMD_BIT_BASE 8'h20
`define DMD_SP_ADDR 8'h81
`define DMD_DPL_ADDR 8'h82
`define DMD_DPH_ADDR 8'h83
`define DMD_PSW_ADDR 8'hD0
`define DMD_ACC_ADDR 8'hE0
`define DMD_PAGE_ADDR 8'hBF
`define DMD_SP_RESET 8'h07
`define DMD_PSW_RESET 8'h00
`define DMD_ACC_RESET 8'h00
`define DMD_DP_RESET 8'h00
`define DMD_PAGE_RESET 8'h00
`define DMD_PSW_RS0_BIT 3
`define DMD_PSW_RS1_BIT 4
`define DMD_FLASH_EN_BIT 0
`define DMD_FLCTL_ADDR 8'hB6
`endif

//--- dmd_pkg.sv
// Types shared by the data-memory decode block.
// Assumes dmd_defs.svh is reachable on the include path.
`include "dmd_defs.svh"
package dmd_pkg;
    typedef enum logic [6:0] {
        DMD_OP_NONE = 7'h01,
        DMD_OP_DIRECT = 7'h02,
        DMD_OP_INDIRECT = 7'h04,
        DMD_OP_BIT = 7'h08,
        DMD_OP_PUSH = 7'h10,
        DMD_OP_POP = 7'h20,
        DMD_OP_EXT = 7'h40
    } dmd_op_e;

    typedef enum logic [1:0] {
        DMD_XS_IDLE = 2'h1,
        DMD_XS_DONE = 2'h2
    } dmd_state_e;

    typedef struct packed {
        dmd_op_e op;
        logic wr;
        logic ptr_sel;
        logic use_ptr;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic bit_val;
        logic [15:0] xaddr;
        logic code_rd;
    } dmd_req_s;

    typedef struct packed {
        logic valid;
        logic [7:0] rdata;
        logic bit_val;
        logic sfr_hit;
        logic sfr_bad;
    } dmd_rsp_s;

    typedef struct packed {
        logic ram_we;
        logic expansion_ram_we;
        logic expansion_ram_re;
        logic flash_wr;
        logic flash_rd;
        logic [15:0] addr;
        logic [7:0] data;
    } dmd_ext_s;
endpackage

//--- dmd_sfr_decode.sv
// Special-register address decode for the paged register space.
// Assumes a registered page select and a direct-mode address above 0x7F.
`timescale 1ns/1ps
`default_nettype none
`include "dmd_defs.svh"
module dmd_sfr_decode (
    input wire logic [7:0] addr, // Direct address.
    input wire logic [7:0] page, // Current page.
    input wire logic [7:0] core_map, // Page on which the page-local register answers.
    output logic bit_ok, // Bit access legal here.
    output logic core_hit, // A core register answers.
    output logic page_hit // Page-local register answers.
);
    import dmd_pkg::*;
    always_comb begin
        bit_ok = (addr[2:0] == 3'h0);
        core_hit = (addr == `DMD_SP_ADDR) || (addr == `DMD_DPL_ADDR) ||
                   (addr == `DMD_DPH_ADDR) || (addr == `DMD_PSW_ADDR) ||
                   (addr == `DMD_ACC_ADDR) || (addr == `DMD_PAGE_ADDR);
        page_hit = (addr == `DMD_FLCTL_ADDR) && (page == core_map);
    end
endmodule
`default_nettype wire

//--- dmd_data_mem.sv
// Data-memory and special-register decode with internal RAM, core registers,
// stack, expansion RAM and code/flash routing.
// Assumes the core issues one request per cycle, steady for that cycle.
`timescale 1ns/1ps
`default_nettype none
`include "dmd_defs.svh"
module dmd_data_mem #(
    parameter int EXPANSION_RAM_DEPTH = 1024,
    parameter int EXPANSION_RAM_AW = 10,
    parameter logic [7:0] FLASH_PAGE = 8'h0F
) (
    input wire logic mclk, // System clock.
    input wire logic sys_rst, // Asynchronous reset, active high.
    input wire dmd_pkg::dmd_req_s req, // Core memory request.
    input wire logic [15:0] sec_limit, // Security location: first locked address.
    output dmd_pkg::dmd_rsp_s rsp, // Registered answer.
    output dmd_pkg::dmd_ext_s ext, // Registered flash and expansion RAM strobes, address and data.
    output logic [7:0] psw_out, // Program status word.
    output logic [7:0] page_out, // Current page select.
    output logic flash_err // Protection violation, one cycle.
);
    import dmd_pkg::*;

    logic [7:0] iram_q [256];
    logic [7:0] iram_d [256];
    logic [7:0] expansion_ram_q [EXPANSION_RAM_DEPTH];
    logic [7:0] sp_q, sp_d, dpl_q, dpl_d, dph_q, dph_d;
    logic [7:0] psw_q, psw_d, acc_q, acc_d, page_q, page_d, flctl_q, flctl_d;
    dmd_rsp_s rsp_q, rsp_d;
    dmd_ext_s ext_q, ext_d;
    logic err_q, err_d;
    logic [7:0] bank_addr, eff_addr, ram_addr, rd_byte, wr_byte, sfr_rd;
    logic [7:0] sfr_addr;
    logic [2:0] bit_pos;
    logic is_ram, bit_ok, core_hit, page_hit, sfr_wr, expansion_ram_wr, expansion_ram_hit;
    logic [EXPANSION_RAM_AW-1:0] xidx;

    dmd_sfr_decode u_sfr (
        .addr(sfr_addr),
        .page(page_q),
        .core_map(FLASH_PAGE),
        .bit_ok(bit_ok),
        .core_hit(core_hit),
        .page_hit(page_hit)
    );

    always_comb begin
        bank_addr = {3'h0, psw_q[`DMD_PSW_RS1_BIT], psw_q[`DMD_PSW_RS0_BIT], 3'h0} +
                    {7'h00, req.ptr_sel};
        // Indirect ops read their pointer from the active bank.
        eff_addr = req.use_ptr ? iram_q[bank_addr] : req.addr;
        bit_pos = req.addr[2:0];
        is_ram = 1'b0;
        ram_addr = eff_addr;
        unique case (req.op)
            DMD_OP_DIRECT: is_ram = (eff_addr <= `DMD_LOW_TOP);
            DMD_OP_INDIRECT: is_ram = 1'b1;
            DMD_OP_PUSH: begin
                is_ram = 1'b1;
                ram_addr = sp_q + 8'h01;
            end
            DMD_OP_POP: begin
                is_ram = 1'b1;
                ram_addr = sp_q;
            end
            DMD_OP_BIT: begin
                is_ram = ~req.addr[7];
                ram_addr = `DMD_BIT_BASE + {4'h0, req.addr[6:3]};
            end
            default: is_ram = 1'b0;
        endcase
        if (req.op == DMD_OP_BIT && req.addr[7]) begin
            ram_addr = {req.addr[7:3], 3'h0};
        end
        // Register decode sees the byte address, also for single-bit operands.
        sfr_addr = (req.op == DMD_OP_BIT) ? ram_addr : eff_addr;
    end

    always_comb begin
        sfr_rd = 8'h00;
        unique case (sfr_addr)
            `DMD_SP_ADDR: sfr_rd = sp_q;
            `DMD_DPL_ADDR: sfr_rd = dpl_q;
            `DMD_DPH_ADDR: sfr_rd = dph_q;
            `DMD_PSW_ADDR: sfr_rd = psw_q;
            `DMD_ACC_ADDR: sfr_rd = acc_q;
            `DMD_PAGE_ADDR: sfr_rd = page_q;
            `DMD_FLCTL_ADDR: sfr_rd = page_hit ? flctl_q : 8'h00;
            default: sfr_rd = 8'h00;
        endcase
        rd_byte = is_ram ? iram_q[ram_addr] : sfr_rd;
        wr_byte = rd_byte;
        wr_byte[bit_pos] = req.bit_val;
        if (req.op != DMD_OP_BIT) begin
            wr_byte = req.wdata;
        end
    end

    always_comb begin
        xidx = req.xaddr[EXPANSION_RAM_AW-1:0];
        expansion_ram_hit = (req.xaddr < 16'(EXPANSION_RAM_DEPTH));
        expansion_ram_wr = 1'b0;
        ext_d = '0;
        err_d = 1'b0;
        ext_d.addr = req.xaddr;
        ext_d.data = req.wdata;
        if (req.op == DMD_OP_EXT) begin
            if (req.code_rd) begin
                // Code reads reach flash only below sec_limit; locked addresses raise the error.
                ext_d.flash_rd = (req.xaddr < sec_limit);
                err_d = (req.xaddr >= sec_limit);
            end else if (req.wr && flctl_q[`DMD_FLASH_EN_BIT]) begin
                ext_d.flash_wr = (req.xaddr < sec_limit);
                err_d = (req.xaddr >= sec_limit);
            end else if (req.wr) begin
                expansion_ram_wr = expansion_ram_hit;
                ext_d.expansion_ram_we = expansion_ram_hit;
            end else begin
                ext_d.expansion_ram_re = expansion_ram_hit;
            end
        end
    end

    always_comb begin
        iram_d = iram_q;
        sp_d = sp_q;
        dpl_d = dpl_q;
        dph_d = dph_q;
        psw_d = psw_q;
        acc_d = acc_q;
        page_d = page_q;
        flctl_d = flctl_q;
        sfr_wr = req.wr && !is_ram && (req.op == DMD_OP_DIRECT ||
                 (req.op == DMD_OP_BIT && bit_ok));
        if ((req.wr || req.op == DMD_OP_PUSH) && is_ram && req.op != DMD_OP_POP) begin
            iram_d[ram_addr] = wr_byte;
        end
        if (req.op == DMD_OP_PUSH) begin
            sp_d = sp_q + 8'h01;
        end else if (req.op == DMD_OP_POP) begin
            sp_d = sp_q - 8'h01;
        end
        if (sfr_wr) begin
            unique case (sfr_addr)
                `DMD_SP_ADDR: sp_d = wr_byte;
                `DMD_DPL_ADDR: dpl_d = wr_byte;
                `DMD_DPH_ADDR: dph_d = wr_byte;
                `DMD_PSW_ADDR: psw_d = wr_byte;
                `DMD_ACC_ADDR: acc_d = wr_byte;
                `DMD_PAGE_ADDR: page_d = wr_byte;
                `DMD_FLCTL_ADDR: flctl_d = page_hit ? wr_byte : flctl_q;
                default: sp_d = sp_d;
            endcase
        end
        rsp_d.valid = (req.op != DMD_OP_NONE);
        rsp_d.rdata = (req.op == DMD_OP_EXT) ? expansion_ram_q[xidx] : rd_byte;
        rsp_d.bit_val = rd_byte[bit_pos];
        rsp_d.sfr_hit = !is_ram && (req.op == DMD_OP_DIRECT || req.op == DMD_OP_BIT);
        rsp_d.sfr_bad = rsp_d.sfr_hit && (!(core_hit || page_hit) ||
                        (req.op == DMD_OP_BIT && !bit_ok));
    end

    // RAM contents survive reset; the registers, the answer, the strobes and the error flag take reset values.
    always_ff @(posedge mclk) begin
        iram_q <= iram_d;
        if (expansion_ram_wr) begin
            expansion_ram_q[xidx] <= req.wdata;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sp_q <= `DMD_SP_RESET;
            dpl_q <= `DMD_DP_RESET;
            dph_q <= `DMD_DP_RESET;
            psw_q <= `DMD_PSW_RESET;
            acc_q <= `DMD_ACC_RESET;
            page_q <= `DMD_PAGE_RESET;
            flctl_q <= 8'h00;
            rsp_q <= '0;
            ext_q <= '0;
            err_q <= 1'b0;
        end else begin
            sp_q <= sp_d;
            dpl_q <= dpl_d;
            dph_q <= dph_d;
            psw_q <= psw_d;
            acc_q <= acc_d;
            page_q <= page_d;
            flctl_q <= flctl_d;
            rsp_q <= rsp_d;
            ext_q <= ext_d;
            err_q <= err_d;
        end
    end

    assign rsp = rsp_q;
    assign ext = ext_q;
    assign psw_out = psw_q;
    assign page_out = page_q;
    assign flash_err = err_q;
endmodule
`default_nettype wire

//--- dmd_data_mem_monitor.sv
// Checker of the decode block's port behaviour.
// Bound from the testbench top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module dmd_data_mem_monitor #(
    parameter int EXPANSION_RAM_DEPTH = 1024
) (
    input wire logic mclk, // Clock.
    input wire logic sys_rst, // Reset.
    input wire dmd_pkg::dmd_req_s req, // Request.
    input wire logic [15:0] sec_limit, // Lock limit.
    input wire dmd_pkg::dmd_rsp_s rsp, // Answer.
    input wire dmd_pkg::dmd_ext_s ext, // Strobes.
    input wire logic [7:0] psw_out, // Status word.
    input wire logic [7:0] page_out, // Page.
    input wire logic flash_err // Lock fault.
);
    import dmd_pkg::*;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    wire logic dw = req.op == DMD_OP_DIRECT && req.wr;
    wire logic cr = req.op == DMD_OP_EXT && req.code_rd && !req.wr;
    a_answer_next: assert property (req.op != DMD_OP_NONE |=> rsp.valid)
        else $error("no answer");
    a_direct_reg: assert property (req.op == DMD_OP_DIRECT && req.addr[7]
        |=> rsp.sfr_hit || rsp.sfr_bad) else $error("no register decode");
    a_indirect_ram: assert property (req.op == DMD_OP_INDIRECT |=> !rsp.sfr_hit)
        else $error("register hit");
    a_page_load: assert property (dw && req.addr == 8'hBF
        |=> page_out == $past(req.wdata)) else $error("page lost");
    a_bank_load: assert property (dw && req.addr == 8'hD0
        |=> psw_out[4:3] == $past(req.wdata[4:3])) else $error("bank lost");
    a_expansion_ram_read: assert property (req.op == DMD_OP_EXT && !req.wr && !req.code_rd
        && req.xaddr < 16'(EXPANSION_RAM_DEPTH)
        |=> ext.expansion_ram_re && !ext.flash_rd) else $error("expansion_ram read lost");
    a_code_read: assert property (cr && req.xaddr < sec_limit |=> ext.flash_rd)
        else $error("code read lost");
    a_lock_read: assert property (cr && req.xaddr >= sec_limit
        |=> flash_err && !ext.flash_rd) else $error("lock missed");
    a_flash_cause: assert property (ext.flash_wr
        |-> $past(req.op) == DMD_OP_EXT && $past(req.wr)) else $error("stray flash write");
    c_push: cover property (req.op == DMD_OP_PUSH);
    c_flash: cover property (ext.flash_wr);
    c_lock: cover property (flash_err);
endmodule
`default_nettype wire

//--- dmd_core_model.sv
// Core-side model issuing one memory request at a time.
// Driven by the testbench through xfer; shares the block's clock.
`timescale 1ns/1ps
`default_nettype none
module dmd_core_model (
    input wire logic mclk, // Clock.
    output dmd_pkg::dmd_req_s req, // Request.
    input wire dmd_pkg::dmd_rsp_s rsp // Answer.
);
    import dmd_pkg::*;
    dmd_rsp_s got;
    initial req = dmd_req_s'({DMD_OP_NONE, 37'h0});
    // Unused registers and registers absent from the current page are named too.
    task automatic xfer(input dmd_req_s r, input int g);
        repeat (g) @(posedge mclk);
        @(posedge mclk) req <= r;
        // Stale fields are inverted so nothing leans on old values.
        @(posedge mclk) req <= dmd_req_s'({DMD_OP_NONE, ~r[36:0]});
        #1 got = rsp;
    endtask
endmodule
`default_nettype wire

//--- data_memory_sfr_decode_tb_top.sv
// Top testbench: a table of core requests, then a mid-run reset.
// Drives the block through the core model; checker bound below.
`timescale 1ns/1ps
`default_nettype none
module data_memory_sfr_decode_tb_top;
    import dmd_pkg::*;
    typedef struct packed {dmd_req_s r; logic [7:0] d; logic [4:0] s;} dmd_row_s;
    localparam dmd_op_e OD = DMD_OP_DIRECT, OI = DMD_OP_INDIRECT, OB = DMD_OP_BIT;
    localparam dmd_op_e OP = DMD_OP_PUSH, OE = DMD_OP_EXT;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] sec_limit = 16'h8000;
    dmd_req_s req;
    dmd_rsp_s rsp;
    dmd_ext_s ext;
    logic [7:0] psw_out;
    logic [7:0] page_out;
    logic flash_err;
    int n_fail = 0;
    int checked = 0;
    dmd_row_s rows[$];
    wire logic [7:0] strb = {3'h0, ext.expansion_ram_we, ext.expansion_ram_re, ext.flash_wr, ext.flash_rd, flash_err};
    initial forever #50 mclk = ~mclk;
    dmd_data_mem #(.EXPANSION_RAM_DEPTH(16), .EXPANSION_RAM_AW(4)) i_dmd_data_mem (.mclk(mclk), .sys_rst(sys_rst),
        .req(req), .sec_limit(sec_limit), .rsp(rsp), .ext(ext), .psw_out(psw_out),
        .page_out(page_out), .flash_err(flash_err));
    dmd_core_model i_dmd_core_model (.mclk(mclk), .req(req), .rsp(rsp));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_sim;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    function automatic void add(dmd_op_e o, int w, logic [7:0] a, logic [7:0] v,
            logic [7:0] d, logic [4:0] s, logic [15:0] x = 16'h0000, logic [2:0] f = 3'h0);
        rows.push_back('{'{o, w[0], f[1], f[0], a, v, v[0], x, f[2]}, d, s});
    endfunction
    // One plain request with no pointer, expansion address or code read.
    task automatic one(input dmd_op_e o, input logic w, input logic [7:0] a, input logic [7:0] v);
        i_dmd_core_model.xfer('{o, w, 1'b0, 1'b0, a, v, v[0], 16'h0000, 1'b0}, 0);
    endtask
    initial begin
        #200000;
        n_fail++;
        end_sim();
    end
    initial begin
        add(OD, 0, 8'h81, 8'h00, 8'h07, 5'h00);
        add(OP, 1, 8'h00, 8'hA5, 8'h00, 5'h00);
        add(OI, 0, 8'h08, 8'h00, 8'hA5, 5'h00);
        add(OD, 0, 8'h81, 8'h00, 8'h08, 5'h00);
        add(OD, 1, 8'h40, 8'h3C, 8'h00, 5'h00);
        add(OI, 1, 8'hD0, 8'h96, 8'h00, 5'h00);
        add(OI, 0, 8'hD0, 8'h00, 8'h96, 5'h00);
        add(OD, 1, 8'hD0, 8'h10, 8'h00, 5'h00);
        add(OD, 1, 8'h11, 8'h40, 8'h00, 5'h00);
        add(OI, 0, 8'h00, 8'h00, 8'h3C, 5'h00, 16'h0000, 3'h3);
        add(OD, 1, 8'h2F, 8'h00, 8'h00, 5'h00);
        add(OB, 1, 8'h7F, 8'h01, 8'h00, 5'h00);
        add(OD, 0, 8'h2F, 8'h00, 8'h80, 5'h00);
        add(OB, 1, 8'hD3, 8'h01, 8'h00, 5'h00);
        add(OD, 0, 8'hD0, 8'h00, 8'h18, 5'h00);
        add(OD, 1, 8'hBF, 8'h0F, 8'h00, 5'h00);
        add(OD, 0, 8'h81, 8'h00, 8'h08, 5'h00);
        add(OD, 1, 8'hB6, 8'h01, 8'h00, 5'h00);
        add(OE, 1, 8'h00, 8'h55, 8'h00, 5'h04, 16'h0100);
        add(OE, 0, 8'h00, 8'h00, 8'h00, 5'h02, 16'h0100, 3'h4);
        add(OE, 0, 8'h00, 8'h00, 8'h00, 5'h01, 16'h9000, 3'h4);
        add(OD, 1, 8'hB6, 8'h00, 8'h00, 5'h00);
        add(OE, 1, 8'h00, 8'h5A, 8'h00, 5'h10, 16'h0005);
        add(OE, 0, 8'h00, 8'h00, 8'h5A, 5'h08, 16'h0005);
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        foreach (rows[i]) begin
            i_dmd_core_model.xfer(rows[i].r, i % 2);
            chk("valid", 8'h01, {7'h00, i_dmd_core_model.got.valid});
            if (!rows[i].r.wr && !rows[i].r.code_rd)
                chk("rdata", rows[i].d, i_dmd_core_model.got.rdata);
            chk("strobes", {3'h0, rows[i].s}, strb);
            chk("sfr_hit", {7'h00, (rows[i].r.op inside {OD, OB}) && rows[i].r.addr[7]},
                {7'h00, i_dmd_core_model.got.sfr_hit});
            if (rows[i].r.op == OE) begin
                chk("xaddr_lo", rows[i].r.xaddr[7:0], ext.addr[7:0]);
                chk("xaddr_hi", rows[i].r.xaddr[15:8], ext.addr[15:8]);
                chk("xdata", rows[i].r.wdata, ext.data);
            end
        end
        one(OB, 1'b0, 8'h7F, 8'h00);
        chk("bit_ram", 8'h01, {7'h00, i_dmd_core_model.got.bit_val});
        one(OB, 1'b0, 8'hD3, 8'h00);
        chk("bit_reg", 8'h01, {7'h00, i_dmd_core_model.got.bit_val});
        chk("bit_reg_ok", 8'h00, {7'h00, i_dmd_core_model.got.sfr_bad});
        one(OD, 1'b0, 8'h90, 8'h00);
        chk("unused", 8'h01, {7'h00, i_dmd_core_model.got.sfr_bad});
        chk("unused_rd", 8'h00, i_dmd_core_model.got.rdata);
        // A handler saves the page, works on page zero, then restores it.
        one(OD, 1'b0, 8'hBF, 8'h00);
        chk("page_save", 8'h0F, i_dmd_core_model.got.rdata);
        one(OD, 1'b1, 8'hBF, 8'h00);
        one(OD, 1'b1, 8'hB6, 8'h01);
        chk("page_absent", 8'h01, {7'h00, i_dmd_core_model.got.sfr_bad});
        one(OD, 1'b1, 8'hBF, 8'h0F);
        one(OD, 1'b0, 8'hB6, 8'h00);
        chk("page_local", 8'h00, i_dmd_core_model.got.rdata);
        chk("page_back", 8'h0F, page_out);
        one(DMD_OP_POP, 1'b0, 8'h00, 8'h00);
        chk("pop", 8'hA5, i_dmd_core_model.got.rdata);
        one(OD, 1'b0, 8'h81, 8'h00);
        chk("pop_sp", 8'h07, i_dmd_core_model.got.rdata);
        @(posedge mclk) sys_rst <= 1'b1;
        @(posedge mclk) sys_rst <= 1'b0;
        i_dmd_core_model.xfer(rows[0].r, 0);
        chk("stack", 8'h07, i_dmd_core_model.got.rdata);
        chk("page", 8'h00, page_out);
        chk("status", 8'h00, psw_out);
        one(OD, 1'b0, 8'h40, 8'h00);
        chk("ram_kept", 8'h3C, i_dmd_core_model.got.rdata);
        end_sim();
    end
endmodule
bind dmd_data_mem dmd_data_mem_monitor #(.EXPANSION_RAM_DEPTH(EXPANSION_RAM_DEPTH)) i_dmd_data_mem_monitor (
    .mclk(mclk), .sys_rst(sys_rst),
    .req(req), .sec_limit(sec_limit), .rsp(rsp), .ext(ext), .psw_out(psw_out),
    .page_out(page_out), .flash_err(flash_err));
`default_nettype wire
